/* File: rtl/drive_status_io.sv */
// Configurable drive terminals and the auto-restart attempt counter.
// Assumes every input synchronous to clk_sys and a single-cycle register port.
//
// Contract
// R01: Second terminal selectable input or output; resets to input, non-inverted.
// R02: First terminal likewise; its role changes only from the configuration tool.
// R03: Selector and output polarity both zero disable the output driver.
// R04: Input polarity resets to pass-through; one inverts the sensed level.
// R05: Selector values one to six make the terminal a status output, high when true.
// R06: Selector one: high when run command absent or no trip active.
// R07: Selector two: high on any trip; three: high while motor running.
// R08: Selector four: high while output frequency below one percent of top limit.
// R09: Selector five: high while frequency within one percent of top limit of setpoint.
// R10: Selector six: high while torque magnitude at or above threshold.
// R11: Output polarity resets to pass-through; one inverts the driven level.
// R12: Auto-reset selected trips and restart, up to a programmed attempt count.
// R13: Attempts used up: stop retrying, stay fault_present_indication until explicit trip reset. Here run command removal also releases the lock.
// R14: Clear attempt count after trip-free run of max(5 minutes, 4 x delay).
// R15: Clear attempt count on successful manual/remote reset or run removal.
// R16: Count each automatic attempt; inhibit further attempts at the maximum.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
module drive_status_io #(
  parameter int TRIP_W         = 16,                    // Number of trip event lines.
  parameter int FREQ_W         = 16,                    // Frequency word width.
  parameter int TORQUE_W       = 16,                    // Torque magnitude width.
  parameter int TICK_CYCLES    = dio_pkg::TICK_CYCLES,  // Clock cycles per millisecond tick.
  parameter int CLEAR_MIN_MS   = dio_pkg::CLEAR_MIN_MS  // Least trip-free run in ticks.
) (
  input  wire logic                     clk_sys,          // System clock, 100 MHz.
  input  wire logic                     sys_rst,          // Asynchronous reset, active high.
  input  wire logic [dio_pkg::ADDR_W-1:0] addr,           // Register byte address.
  input  wire logic [dio_pkg::DATA_W-1:0] wrData,         // Register write data.
  input  wire logic                     wrStrobe,         // Write strobe, one cycle.
  input  wire logic                     rdStrobe,         // Read strobe, one cycle.
  input  wire logic                     toolAccess,       // Access from the configuration tool.
  output logic [dio_pkg::DATA_W-1:0]    rdData,           // Read data, cycle after rdStrobe.
  input  wire logic                     runCommandInput,  // Run command level.
  input  wire logic [TRIP_W-1:0]        tripActive,       // Active trip events.
  input  wire logic                     motorRunning,     // Motor running level.
  input  wire logic [FREQ_W-1:0]        outputFreq,       // Output frequency magnitude.
  input  wire logic [FREQ_W-1:0]        setpointFreq,     // Frequency setpoint magnitude.
  input  wire logic [FREQ_W-1:0]        maxFreq,          // Top frequency limit.
  input  wire logic [TORQUE_W-1:0]      outputTorque,     // Output torque magnitude.
  input  wire logic                     remoteTripReset,  // Remote trip reset pulse.
  input  wire logic                     firstTerminalPin, // First terminal pin level in.
  input  wire logic                     secondTerminalPin, // Second terminal pin level in.
  output logic                          firstTerminalOutput, // First terminal drive level.
  output logic                          firstTerminalOe,  // First terminal driver enable.
  output logic                          secondTerminalOutput, // Second terminal drive level.
  output logic                          secondTerminalOe, // Second terminal driver enable.
  output logic                          firstTerminalInput, // First terminal sensed level.
  output logic                          secondTerminalInput, // Second terminal sensed level.
  output logic                          autoTripReset,    // Automatic trip reset pulse.
  output logic                          manualTripReset,  // Software trip reset pulse.
  output logic                          restartLocked,    // Attempts exhausted, drive held fault_present_indication.
  output logic [3:0]                    attemptCount,     // Restart attempts made.
  output logic                          irq               // Interrupt, level, active high.
);

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam int RUN_W = 20;
  localparam logic [RUN_W-1:0] CLEAR_MIN = RUN_W'(CLEAR_MIN_MS);
  localparam int SCALE_W = FREQ_W + 7;

  generate
    if (TRIP_W < 1 || TRIP_W > 16) begin : g_bad_trip
      $error("TRIP_W must be 1 to 16");
    end
    if (TICK_CYCLES < 1) begin : g_bad_tick
      $error("TICK_CYCLES must be at least 1");
    end
    if (CLEAR_MIN_MS < 1 || CLEAR_MIN_MS >= (1 << RUN_W)) begin : g_bad_clear
      $error("CLEAR_MIN_MS out of range");
    end
    if (FREQ_W < 1 || FREQ_W > 24 || TORQUE_W < 1 || TORQUE_W > 16) begin : g_bad_width
      $error("Frequency or torque width out of range");
    end
  endgenerate

  // Terminal configuration, index 0 is the first terminal, 1 the second.
  logic [2:0]        srcSel [2];
  logic [1:0]        outInv;
  logic [1:0]        inInv;
  logic [TRIP_W-1:0] tripSelect;
  logic [3:0]        restartMax;
  logic [15:0]       restartDelay;
  logic [TORQUE_W-1:0] torqueLevel;
  logic [dio_pkg::IRQ_W-1:0] irqStatus;
  logic [dio_pkg::IRQ_W-1:0] irqMask;

  logic [1:0] pinIn;
  logic [1:0] pinOut;
  logic [1:0] pinOe;
  logic [1:0] sensed;

  dio_pkg::restart_state_t state;
  logic [TICK_W-1:0] tickCount;
  logic              msTick;
  logic [15:0]       delayMs;
  logic [RUN_W-1:0]  tripFreeMs;
  logic              manualPending;

  logic wrFirst;
  logic wrSecond;
  logic wrIrqStatus;
  logic wrTripReset;
  logic anyTrip;
  logic selTrip;
  logic manualDone;
  logic attemptEvent;
  logic exhaustedEvent;
  logic clearedEvent;
  logic [dio_pkg::IRQ_W-1:0] irqEvents;
  logic [RUN_W-1:0] clearLimit;
  logic [6:0]       conditions;
  logic [SCALE_W-1:0] scaledOut;
  logic [SCALE_W-1:0] scaledDiff;
  logic [FREQ_W-1:0]  freqDiff;
  logic [dio_pkg::DATA_W-1:0] next_rdData;

  assign pinIn = {secondTerminalPin, firstTerminalPin};
  assign firstTerminalOutput  = pinOut[0];
  assign firstTerminalOe      = pinOe[0];
  assign secondTerminalOutput = pinOut[1];
  assign secondTerminalOe     = pinOe[1];
  assign firstTerminalInput   = sensed[0];
  assign secondTerminalInput  = sensed[1];

  assign wrFirst     = wrStrobe && (addr == dio_pkg::OFS_CTRL_FIRST) && toolAccess; // see R02
  assign wrSecond    = wrStrobe && (addr == dio_pkg::OFS_CTRL_SECOND);
  assign wrIrqStatus = wrStrobe && (addr == dio_pkg::OFS_IRQ_STATUS);
  assign wrTripReset = wrStrobe && (addr == dio_pkg::OFS_TRIP_RESET) && wrData[dio_pkg::TRIP_RESET_BIT];

  assign anyTrip = |tripActive;
  assign selTrip = |(tripActive & tripSelect);

  // Status conditions, indexed by selector code; index 0 is never driven out.
  assign scaledOut  = SCALE_W'(outputFreq) * SCALE_W'(dio_pkg::PERCENT);
  assign freqDiff   = (outputFreq >= setpointFreq) ? (outputFreq - setpointFreq) : (setpointFreq - outputFreq);
  assign scaledDiff = SCALE_W'(freqDiff) * SCALE_W'(dio_pkg::PERCENT);

  always_comb begin
    conditions = 7'h00;
    conditions[dio_pkg::SEL_NO_FAULT]  = !runCommandInput || !anyTrip;          // see R06
    conditions[dio_pkg::SEL_FAULT]     = anyTrip;                               // see R07
    conditions[dio_pkg::SEL_RUNNING]   = motorRunning;                          // see R07
    conditions[dio_pkg::SEL_NEAR_ZERO] = scaledOut < SCALE_W'(maxFreq);         // see R08
    conditions[dio_pkg::SEL_ON_TARGET] = scaledDiff <= SCALE_W'(maxFreq);       // see R09
    conditions[dio_pkg::SEL_TORQUE]    = outputTorque >= torqueLevel;           // see R10
  end

  genvar t;
  generate
    for (t = 0; t < 2; t++) begin : g_term
      status_source_mux u_mux (
        .clk_sys        (clk_sys),
        .sys_rst        (sys_rst),
        .sourceSelect   (srcSel[t]),
        .polarityInvert (outInv[t]),
        .conditions     (conditions),
        .pinOut         (pinOut[t]),
        .pinOe          (pinOe[t])
      );

      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          sensed[t] <= 1'b0;
        end else begin
          sensed[t] <= pinIn[t] ^ inInv[t]; // see R04
        end
      end
    end
  endgenerate

  // Terminal configuration; both terminals come up as non-inverted inputs.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      srcSel[0] <= dio_pkg::SEL_NONE; // see R01
      srcSel[1] <= dio_pkg::SEL_NONE; // see R01
      outInv    <= 2'h0;
      inInv     <= 2'h0;             // see R04
    end else begin
      if (wrFirst) begin
        srcSel[0] <= wrData[dio_pkg::SEL_LSB +: dio_pkg::SEL_W];
        outInv[0] <= wrData[dio_pkg::OUT_INV_BIT];
        inInv[0]  <= wrData[dio_pkg::IN_INV_BIT];
      end
      if (wrSecond) begin
        srcSel[1] <= wrData[dio_pkg::SEL_LSB +: dio_pkg::SEL_W];
        outInv[1] <= wrData[dio_pkg::OUT_INV_BIT];
        inInv[1]  <= wrData[dio_pkg::IN_INV_BIT];
      end
    end
  end

  // Restart parameters.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tripSelect   <= '0;
      restartMax   <= dio_pkg::RESTART_MAX_RST;
      restartDelay <= dio_pkg::RESTART_DELAY_RST;
      torqueLevel  <= TORQUE_W'(dio_pkg::TORQUE_LEVEL_RST);
    end else if (wrStrobe) begin
      unique case (addr)
        dio_pkg::OFS_TRIP_SELECT:   tripSelect   <= wrData[TRIP_W-1:0];
        dio_pkg::OFS_RESTART_MAX:   restartMax   <= wrData[3:0];
        dio_pkg::OFS_RESTART_DELAY: restartDelay <= wrData[15:0];
        dio_pkg::OFS_TORQUE_LEVEL:  torqueLevel  <= wrData[TORQUE_W-1:0];
        default: ;
      endcase
    end
  end

  // Millisecond tick for the restart delay and trip-free timer.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tickCount <= '0;
      msTick    <= 1'b0;
    end else if (tickCount == TICK_LAST) begin
      tickCount <= '0;
      msTick    <= 1'b1;
    end else begin
      tickCount <= tickCount + 1'b1;
      msTick    <= 1'b0;
    end
  end

  // A trip reset stays pending until no trip is left, which marks it successful, or until the run command is removed.
  assign manualDone = manualPending && !anyTrip;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      manualPending   <= 1'b0;
      manualTripReset <= 1'b0;
    end else begin
      manualTripReset <= wrTripReset;
      if (wrTripReset || remoteTripReset) begin
        manualPending <= 1'b1;
      end else if (manualDone || !runCommandInput) begin
        manualPending <= 1'b0;
      end
    end
  end

  // Auto-restart sequencer.
  assign attemptEvent   = (state == dio_pkg::RS_DELAY) && runCommandInput && selTrip
                          && msTick && (delayMs >= restartDelay);
  assign exhaustedEvent = (state == dio_pkg::RS_IDLE) && runCommandInput && selTrip
                          && (attemptCount >= restartMax);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state         <= dio_pkg::RS_IDLE;
      delayMs       <= 16'h0000;
      autoTripReset <= 1'b0;
      restartLocked <= 1'b0;
    end else begin
      autoTripReset <= attemptEvent; // see R12
      unique case (state)
        dio_pkg::RS_IDLE: begin
          delayMs <= 16'h0000;
          if (exhaustedEvent) begin
            state         <= dio_pkg::RS_LOCKED; // see R16
            restartLocked <= 1'b1;
          end else if (runCommandInput && selTrip) begin
            state <= dio_pkg::RS_DELAY; // see R12
          end
        end
        dio_pkg::RS_DELAY: begin
          if (!runCommandInput || !selTrip) begin
            state <= dio_pkg::RS_IDLE;
          end else if (attemptEvent) begin
            state <= dio_pkg::RS_RESET;
          end else if (msTick) begin
            delayMs <= delayMs + 16'h0001;
          end
        end
        dio_pkg::RS_RESET: begin
          // Hold until the reset trips fall, so one trip costs exactly one attempt.
          if (!runCommandInput || !selTrip) begin
            state <= dio_pkg::RS_IDLE;
          end
        end
        dio_pkg::RS_LOCKED: begin
          // No retry from here; only an explicit reset or run removal releases it.
          if (manualDone || !runCommandInput) begin // see R13
            state         <= dio_pkg::RS_IDLE;
            restartLocked <= 1'b0;
          end
        end
      endcase
    end
  end

  // Trip-free run timer.
  assign clearLimit = (RUN_W'(restartDelay) * RUN_W'(dio_pkg::DELAY_MULT) > CLEAR_MIN)
                      ? RUN_W'(restartDelay) * RUN_W'(dio_pkg::DELAY_MULT) : CLEAR_MIN; // see R14
  assign clearedEvent = msTick && (tripFreeMs == clearLimit - 1'b1) && (attemptCount != 4'h0);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tripFreeMs <= '0;
    end else if (!runCommandInput || !motorRunning || anyTrip) begin
      tripFreeMs <= '0;
    end else if (msTick && tripFreeMs < clearLimit) begin
      tripFreeMs <= tripFreeMs + 1'b1;
    end
  end

  // Attempt counter; any clearing cause wins over a same-cycle attempt.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      attemptCount <= 4'h0;
    end else if (!runCommandInput || manualDone) begin // see R15
      attemptCount <= 4'h0;
    end else if (clearedEvent) begin // see R14
      attemptCount <= 4'h0;
    end else if (attemptEvent && attemptCount != 4'hF) begin // see R16
      attemptCount <= attemptCount + 4'h1;
    end
  end

  // Interrupts: sticky status, write one to clear, a new event wins over its clear.
  always_comb begin
    irqEvents = '0;
    irqEvents[dio_pkg::IRQ_ATTEMPT]   = attemptEvent;
    irqEvents[dio_pkg::IRQ_EXHAUSTED] = exhaustedEvent;
    irqEvents[dio_pkg::IRQ_CLEARED]   = clearedEvent;
    irqEvents[dio_pkg::IRQ_IN_FIRST]  = sensed[0] != (pinIn[0] ^ inInv[0]);
    irqEvents[dio_pkg::IRQ_IN_SECOND] = sensed[1] != (pinIn[1] ^ inInv[1]);
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irqStatus <= '0;
      irqMask   <= '0;
      irq       <= 1'b0;
    end else begin
      irqStatus <= (irqStatus & ~(wrIrqStatus ? wrData[dio_pkg::IRQ_W-1:0] : '0)) | irqEvents;
      if (wrStrobe && addr == dio_pkg::OFS_IRQ_MASK) begin
        irqMask <= wrData[dio_pkg::IRQ_W-1:0];
      end
      irq <= |(((irqStatus & ~(wrIrqStatus ? wrData[dio_pkg::IRQ_W-1:0] : '0)) | irqEvents) & irqMask);
    end
  end

  // Read path; data stand only in the cycle after the strobe, unmapped addresses read zero.
  always_comb begin
    next_rdData = '0;
    if (rdStrobe) begin
      unique case (addr)
        dio_pkg::OFS_CTRL_FIRST, dio_pkg::OFS_CTRL_SECOND: begin
          next_rdData[dio_pkg::SEL_LSB +: dio_pkg::SEL_W] = (addr == dio_pkg::OFS_CTRL_FIRST) ? srcSel[0] : srcSel[1];
          next_rdData[dio_pkg::OUT_INV_BIT] = (addr == dio_pkg::OFS_CTRL_FIRST) ? outInv[0] : outInv[1];
          next_rdData[dio_pkg::IN_INV_BIT]  = (addr == dio_pkg::OFS_CTRL_FIRST) ? inInv[0] : inInv[1];
        end
        dio_pkg::OFS_TRIP_SELECT:   next_rdData[TRIP_W-1:0] = tripSelect;
        dio_pkg::OFS_RESTART_MAX:   next_rdData[3:0] = restartMax;
        dio_pkg::OFS_RESTART_DELAY: next_rdData[15:0] = restartDelay;
        dio_pkg::OFS_TORQUE_LEVEL:  next_rdData[TORQUE_W-1:0] = torqueLevel;
        dio_pkg::OFS_STATUS: begin
          next_rdData[dio_pkg::ST_COUNT_LSB +: 4] = attemptCount;
          next_rdData[dio_pkg::ST_STATE_LSB +: 2] = state;
          next_rdData[dio_pkg::ST_IN_LSB +: 2]    = sensed;
          next_rdData[dio_pkg::ST_OE_LSB +: 2]    = pinOe;
          next_rdData[dio_pkg::ST_OUT_LSB +: 2]   = pinOut;
          next_rdData[dio_pkg::ST_TRIP_LSB +: TRIP_W] = tripActive;
        end
        dio_pkg::OFS_IRQ_STATUS:    next_rdData[dio_pkg::IRQ_W-1:0] = irqStatus;
        dio_pkg::OFS_IRQ_MASK:      next_rdData[dio_pkg::IRQ_W-1:0] = irqMask;
        default:                    next_rdData = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdData <= '0;
    end else begin
      rdData <= next_rdData;
    end
  end

endmodule

/* File: inc/dio_pkg.sv */
// Constants for the drive terminals and the auto-restart logic.
// Assumes a 100 MHz clock and the plain register port.
package dio_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL_FIRST    = 8'h00;
  localparam logic [7:0] OFS_CTRL_SECOND   = 8'h04;
  localparam logic [7:0] OFS_TRIP_SELECT   = 8'h08;
  localparam logic [7:0] OFS_RESTART_MAX   = 8'h0C;
  localparam logic [7:0] OFS_RESTART_DELAY = 8'h10;
  localparam logic [7:0] OFS_TORQUE_LEVEL  = 8'h14;
  localparam logic [7:0] OFS_STATUS        = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS    = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK      = 8'h20;
  localparam logic [7:0] OFS_TRIP_RESET    = 8'h24;

  // Terminal control register layout.
  localparam int SEL_LSB     = 0;
  localparam int SEL_W       = 3;
  localparam int OUT_INV_BIT = 3;
  localparam int IN_INV_BIT  = 4;

  // Output source selector codes.
  localparam logic [2:0] SEL_NONE     = 3'h0;
  localparam logic [2:0] SEL_NO_FAULT = 3'h1;
  localparam logic [2:0] SEL_FAULT    = 3'h2;
  localparam logic [2:0] SEL_RUNNING  = 3'h3;
  localparam logic [2:0] SEL_NEAR_ZERO = 3'h4;
  localparam logic [2:0] SEL_ON_TARGET = 3'h5;
  localparam logic [2:0] SEL_TORQUE   = 3'h6;

  // Reset values.
  localparam logic [3:0]  RESTART_MAX_RST   = 4'h3;
  localparam logic [15:0] RESTART_DELAY_RST = 16'h0064;
  localparam logic [15:0] TORQUE_LEVEL_RST  = 16'h0000;

  // Interrupt status and mask bit positions.
  localparam int IRQ_ATTEMPT   = 0;
  localparam int IRQ_EXHAUSTED = 1;
  localparam int IRQ_CLEARED   = 2;
  localparam int IRQ_IN_FIRST  = 3;
  localparam int IRQ_IN_SECOND = 4;
  localparam int IRQ_W         = 5;

  // Status register layout.
  localparam int ST_COUNT_LSB = 0;
  localparam int ST_STATE_LSB = 4;
  localparam int ST_IN_LSB    = 8;
  localparam int ST_OE_LSB    = 10;
  localparam int ST_OUT_LSB   = 12;
  localparam int ST_TRIP_LSB  = 16;

  localparam int TRIP_RESET_BIT = 0;

  // Timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int CLEAR_MIN_MINUTES = 5;
  localparam int CLEAR_MIN_MS  = CLEAR_MIN_MINUTES * 60 * 1000;
  localparam int DELAY_MULT    = 4;
  localparam int PERCENT       = 100;

  typedef enum logic [1:0] {
    RS_IDLE   = 2'b00,
    RS_DELAY  = 2'b01,
    RS_RESET  = 2'b10,
    RS_LOCKED = 2'b11
  } restart_state_t;

endpackage

/* File: rtl/status_source_mux.sv */
// One terminal's output stage: condition select, polarity and driver enable.
// Assumes the condition vector is synchronous to clk_sys.
`timescale 1ns/10ps
module status_source_mux (
  input  wire logic       clk_sys,      // System clock.
  input  wire logic       sys_rst,      // Asynchronous reset, active high.
  input  wire logic [2:0] sourceSelect, // Output source selector.
  input  wire logic       polarityInvert, // Output polarity control.
  input  wire logic [6:0] conditions,   // Status conditions, index is selector code.
  output logic            pinOut,       // Registered pin level.
  output logic            pinOe         // Registered driver enable.
);

  logic picked;

  always_comb begin
    unique case (sourceSelect)
      dio_pkg::SEL_NO_FAULT,
      dio_pkg::SEL_FAULT,
      dio_pkg::SEL_RUNNING,
      dio_pkg::SEL_NEAR_ZERO,
      dio_pkg::SEL_ON_TARGET,
      dio_pkg::SEL_TORQUE:   picked = conditions[sourceSelect]; // see R05
      default:               picked = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pinOut <= 1'b0;
      pinOe  <= 1'b0;
    end else begin
      // Selector and polarity both zero leave the terminal as a pure input.
      pinOe  <= (sourceSelect != dio_pkg::SEL_NONE) || polarityInvert; // see R03
      pinOut <= picked ^ polarityInvert; // see R11
    end
  end

endmodule

/* File: tb/drive_status_io_sva.sv */
// Checker for the terminal stages and restart counter.
// Assumes one clk_sys domain, sys_rst async and high.
`timescale 1ns/10ps
module drive_status_io_sva (
  input wire logic        clk_sys,              // System clock.
  input wire logic        sys_rst,              // Reset, active high.
  input wire logic        runCommandInput,      // Run command level.
  input wire logic [15:0] tripActive,           // Active trips.
  input wire logic        remoteTripReset,      // Remote reset pulse.
  input wire logic        firstTerminalOutput,  // First drive level.
  input wire logic        firstTerminalOe,      // First driver enable.
  input wire logic        secondTerminalOutput, // Second drive level.
  input wire logic        secondTerminalOe,     // Second driver enable.
  input wire logic        autoTripReset,        // Automatic reset pulse.
  input wire logic        restartLocked,        // Attempts used up.
  input wire logic [3:0]  attemptCount          // Attempts made.
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  oe_off_first_a: assert property (!firstTerminalOe |-> !firstTerminalOutput)
    else $error("first pin high, driver off");
  oe_off_second_a: assert property (!secondTerminalOe |-> !secondTerminalOutput)
    else $error("second pin high, driver off");
  run_clear_a: assert property (!runCommandInput |=> attemptCount == 4'h0)
    else $error("count kept, run off");
  locked_quiet_a: assert property (restartLocked |-> !autoTripReset)
    else $error("attempt while locked");
  auto_pulse_a: assert property (autoTripReset |=> !autoTripReset)
    else $error("auto reset too long");
  count_step_a: assert property ($changed(attemptCount) |->
    attemptCount == 4'h0 || attemptCount == $past(attemptCount) + 4'h1)
    else $error("count jumped");
  count_cause_a: assert property ($changed(attemptCount) && attemptCount != 4'h0 |->
    autoTripReset || $past(autoTripReset))
    else $error("count rose alone");
  remote_clear_a: assert property (remoteTripReset && tripActive == 16'h0000 |->
    ##[1:3] attemptCount == 4'h0)
    else $error("count kept, remote reset");
endmodule
bind drive_status_io drive_status_io_sva drive_status_io_sva_inst (.clk_sys, .sys_rst, .runCommandInput,
  .tripActive, .remoteTripReset, .firstTerminalOutput, .firstTerminalOe, .secondTerminalOutput,
  .secondTerminalOe, .autoTripReset, .restartLocked, .attemptCount);

/* File: tb/field_wiring.sv */
// Field wiring on one terminal: lamp or relay, else switch contact.
// Assumes the contact level is set by the bench; no pull on the wire.
`timescale 1ns/10ps
module field_wiring (
  input  wire logic drive,   // Terminal drive level.
  input  wire logic oe,      // Terminal driver enable.
  input  wire logic contact, // Switch contact level.
  output logic      pin      // Resolved pin level.
);
  // A driven terminal wins over the contact.
  assign pin = oe ? drive : contact;
endmodule

/* File: tb/drive_status_io_tb.sv */
// Bench for terminals and auto-restart, short tick and clear counts.
// Assumes field_wiring on both pins, checker bound in.
`timescale 1ns/10ps
module drive_status_io_tb;
  logic clk_sys = 0, sys_rst = 1, wrStrobe = 0, rdStrobe = 0, toolAccess = 0, runCommandInput = 0;
  logic motorRunning = 0, remoteTripReset = 0, c1 = 0, c2 = 0, p1, p2, o1, e1, o2, e2, i1, i2;
  logic autoTripReset, manualTripReset, restartLocked, irq;
  logic [7:0] addr = 8'h00;
  logic [31:0] wrData = 32'h0, rdData;
  logic [15:0] tripActive = 16'h0, outputFreq = 16'h0, setpointFreq = 16'h0, maxFreq = 16'h0064;
  logic [15:0] outputTorque = 16'h0;
  logic [3:0] attemptCount;
  int fails = 0, check_count = 0;
  always #5 clk_sys = ~clk_sys;
  drive_status_io #(.TICK_CYCLES(4), .CLEAR_MIN_MS(20)) drive_status_io_inst (.clk_sys, .sys_rst, .addr,
    .wrData, .wrStrobe, .rdStrobe, .toolAccess, .rdData, .runCommandInput, .tripActive, .motorRunning,
    .outputFreq, .setpointFreq, .maxFreq, .outputTorque, .remoteTripReset, .firstTerminalPin(p1),
    .secondTerminalPin(p2), .firstTerminalOutput(o1), .firstTerminalOe(e1), .secondTerminalOutput(o2),
    .secondTerminalOe(e2), .firstTerminalInput(i1), .secondTerminalInput(i2), .autoTripReset,
    .manualTripReset, .restartLocked, .attemptCount, .irq);
  field_wiring field_wiring_inst (.drive(o1), .oe(e1), .contact(c1), .pin(p1));
  field_wiring field_wiring_inst2 (.drive(o2), .oe(e2), .contact(c2), .pin(p2));
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys) {wrStrobe, addr, wrData} <= {1'b1, a, d};
    @(posedge clk_sys) wrStrobe <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys) {rdStrobe, addr} <= {1'b1, a};
    @(posedge clk_sys) rdStrobe <= 1'b0;
    #1 chk(rdData, exp);
  endtask
  task waitfor(input int w);
    int n;
    n = 0;
    while ((w == 0 ? autoTripReset : w == 1 ? restartLocked : attemptCount == 4'h0) !== 1'b1) begin
      @(posedge clk_sys);
      #1 n++;
      if (n > 400) begin
        fails++;
        tally_and_finish;
      end
    end
  endtask
  task t_reset_and_input;
    rd(dio_pkg::OFS_CTRL_SECOND, 32'h0);
    rd(dio_pkg::OFS_RESTART_MAX, 32'h3);
    rd(8'h28, 32'h0);
    chk({e1, e2}, 2'b00);
    {c1, c2} <= 2'b11;
    repeat (2) @(posedge clk_sys);
    #1 chk({i1, i2}, 2'b11);
    wr(dio_pkg::OFS_CTRL_SECOND, 32'h10);
    @(posedge clk_sys);
    #1 chk({i1, i2}, 2'b10);
    wr(dio_pkg::OFS_CTRL_FIRST, 32'h3);
    rd(dio_pkg::OFS_CTRL_FIRST, 32'h0);
    toolAccess <= 1'b1;
    wr(dio_pkg::OFS_CTRL_FIRST, 32'h9);
    @(posedge clk_sys);
    #1 chk({e1, o1}, 2'b10);
  endtask
  task t_sources;
    logic [6:0] ca, cb;
    ca = 7'b1111010;
    cb = 7'b0000100;
    wr(dio_pkg::OFS_TORQUE_LEVEL, 32'h6);
    for (int s = 0; s < 24; s++) begin
      runCommandInput <= 1'b1;
      {tripActive, motorRunning, outputFreq, setpointFreq, outputTorque} <= s[0] ?
        {16'h1, 1'b0, 16'h1, 16'h3, 16'h5} : {16'h0, 1'b1, 16'h0, 16'h0, 16'h6};
      wr(dio_pkg::OFS_CTRL_SECOND, {28'h0, s[1], 3'(s / 4 + 1)});
      repeat (2) @(posedge clk_sys);
      #1 chk({e2, o2, i2}, {1'b1, {2{(s[0] ? cb[s/4+1] : ca[s/4+1]) ^ s[1]}}});
    end
    wr(dio_pkg::OFS_CTRL_SECOND, 32'h0);
    @(posedge clk_sys);
    #1 chk(e2, 1'b0);
  endtask
  task attempt(input logic [3:0] n);
    @(posedge clk_sys) tripActive <= 16'h1;
    waitfor(0);
    @(posedge clk_sys) tripActive <= 16'h0;
    #1 chk(attemptCount, n);
  endtask
  task t_restart;
    tripActive <= 16'h0;
    wr(dio_pkg::OFS_TRIP_SELECT, 32'h1);
    wr(dio_pkg::OFS_RESTART_MAX, 32'h2);
    wr(dio_pkg::OFS_RESTART_DELAY, 32'h1);
    wr(dio_pkg::OFS_IRQ_MASK, 32'h1);
    attempt(4'h1);
    chk(irq, 1'b1);
    wr(dio_pkg::OFS_IRQ_STATUS, 32'h1);
    @(posedge clk_sys);
    #1 chk(irq, 1'b0);
    attempt(4'h2);
    @(posedge clk_sys) tripActive <= 16'h1;
    waitfor(1);
    wr(dio_pkg::OFS_TRIP_RESET, 32'h1);
    #1 chk(manualTripReset, 1'b1);
    tripActive <= 16'h0;
    @(posedge clk_sys) remoteTripReset <= 1'b1;
    @(posedge clk_sys) remoteTripReset <= 1'b0;
    waitfor(2);
    repeat (2) @(posedge clk_sys);
    #1 chk(restartLocked, 1'b0);
    attempt(4'h1);
    runCommandInput <= 1'b0;
    waitfor(2);
    @(posedge clk_sys) runCommandInput <= 1'b1;
    motorRunning <= 1'b1;
    attempt(4'h1);
    repeat (40) @(posedge clk_sys);
    #1 chk(attemptCount, 4'h1);
    waitfor(2);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset_and_input;
    t_sources;
    t_restart;
    tally_and_finish;
  end
endmodule
